// ### test/dsp_host.sv
// Partner: host processor model driving the port pins
module dsp_host (
  input  wire logic       clk,
  input  wire logic       style,
  input  wire logic [7:0] bus,
  output logic            cs_n,
  output logic            re,
  output logic            wd,
  output logic            rs,
  output logic      [7:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // Idle pins from time zero, so the synchronisers never see unknowns
  initial begin
    cs_n = 1'b1;
    re   = 1'b1;
    wd   = 1'b1;
    rs   = 1'b0;
    dq   = 8'h00;
  end
  // ====
  // Access cycle, held whole strobe; released bus shows inverse
  task automatic acc(input logic w, a, c, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    cs_n = c;
    rs = a;
    dq = w ? d : ~dq;
    wd = !w;
    re = style ? 1'b1 : w;
    repeat (6) @(posedge clk);
    q = bus;
    #1;
    cs_n = 1'b1;
    re = !style;
    wd = 1'b1;
    dq = ~dq;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### test/dsp_port_props.sv
// Checker: host port timing and scan properties
module dsp_port_props
  import dsp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       controller_clear_n,
  input wire logic       bus_style_select,
  input wire logic       chip_select_n,
  input wire logic       read_enable,
  input wire logic       write_direction,
  input wire logic       register_select,
  input wire logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic       host_data_bus_oe_n,
  input wire logic       ready,
  input wire logic       row_strobe,
  input wire logic [7:0] last_data,
  input wire logic [7:0] last_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // Access decode and frame counters
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic sel = !chip_select_n && controller_clear_n;
  wire logic idle = bus_style_select ? !read_enable : read_enable;
  wire logic rd = sel && write_direction && !idle;
  wire logic wr = sel && !write_direction && read_enable;
  logic [7:0] rows_ff;
  logic [9:0] hi_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rows_ff <= 8'h00;
      hi_ff   <= 10'h000;
    end else begin
      rows_ff <= ready ? 8'h00 : rows_ff + 8'(row_strobe);
      hi_ff   <= ready ? hi_ff + 10'h001 : 10'h000;
    end
  end
  a_bus_float: assert property (chip_select_n[*6] |-> host_data_bus_oe_n)
    else $error("bus driven while deselected");
  a_read_idle: assert property (idle[*6] |-> host_data_bus_oe_n)
    else $error("bus driven without read strobe");
  a_read_drive: assert property (rd[*6] |-> !host_data_bus_oe_n)
    else $error("read not answered");
  a_status_bits: assert property ((rd && !register_select)[*6] |-> host_data_bus_out[5:0] == 6'h00)
    else $error("status low bits not zero");
  a_data_store: assert property ((wr && !register_select)[*6] |-> last_data == host_data_bus_in)
    else $error("data write not stored");
  a_cmd_store: assert property ((wr && register_select)[*6] |-> last_cmd == host_data_bus_in)
    else $error("command write not stored");
  a_rows_frame: assert property ($rose(ready) |-> rows_ff + 8'(row_strobe) == 8'(ROWS))
    else $error("wrong row count before ready");
  a_ready_lead: assert property ($fell(ready) |-> hi_ff == 10'(READY_LEAD_CYC) ##1 !row_strobe[*8])
    else $error("ready low lead wrong");
endmodule
bind dsp_port dsp_port_props u_dsp_port_props (.clk(clk), .rst_n(rst_n),
  .controller_clear_n(controller_clear_n), .bus_style_select(bus_style_select),
  .chip_select_n(chip_select_n), .read_enable(read_enable), .write_direction(write_direction),
  .register_select(register_select), .host_data_bus_in(host_data_bus_in),
  .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_n(host_data_bus_oe_n),
  .ready(ready), .row_strobe(row_strobe), .last_data(last_data), .last_cmd(last_cmd));

// ### test/tb.sv
// Testbench: host accesses in both bus styles against a model
module tb;
  import dsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sty = 1'b0;
  logic clr_n = 1'b1;
  logic cs_n, re, wd, rs, oe_n, rdy, rstb, a;
  logic [7:0] dq, out, ld, lc, q, d, bus;
  int errors = 0;
  int checks = 0;
  int m_d, m_c;
  assign bus = oe_n ? dq : out;
  always #5 clk = ~clk;
  dsp_port u_dsp_port (.clk(clk), .rst_n(rst_n), .controller_clear_n(clr_n),
    .bus_style_select(sty), .chip_select_n(cs_n), .read_enable(re), .write_direction(wd),
    .register_select(rs), .self_check_pin(1'b1), .host_data_bus_in(bus),
    .host_data_bus_out(out), .host_data_bus_oe_n(oe_n), .ready(rdy), .row_strobe(rstb),
    .last_data(ld), .last_cmd(lc));
  dsp_host u_dsp_host (.clk(clk), .style(sty), .bus(bus), .cs_n(cs_n), .re(re),
    .wd(wd), .rs(rs), .dq(dq));
  task chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    final_report;
  end
  initial begin
    void'($urandom(32'hb998_781c));
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      sty = s[0];
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (8) @(posedge clk);
      m_d = 0;
      m_c = 0;
      chk(ld, 8'h00);
      for (int i = 0; i < 6; i++) begin
        d = 8'($urandom);
        a = 1'($urandom);
        u_dsp_host.acc(1'b1, a, 1'b0, d, q);
        if (a) m_c = d;
        else m_d = d;
        chk(ld, 8'(m_d));
        chk(lc, 8'(m_c));
        u_dsp_host.acc(1'b0, 1'b1, 1'b0, 8'h00, q);
        chk(q, 8'(m_d));
      end
      u_dsp_host.acc(1'b0, 1'b0, 1'b0, 8'h00, q);
      chk(q & 8'h3f, 8'h00);
      u_dsp_host.acc(1'b1, 1'b0, 1'b1, ~d, q);
      chk(ld, 8'(m_d));
      @(posedge clk);
      #1;
      clr_n = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      clr_n = 1'b1;
      repeat (4) @(posedge clk);
      chk(ld, 8'h00);
      chk(lc, 8'h00);
    end
    repeat (32000) @(posedge clk);
    final_report;
  end
endmodule

// ### verilog/dsp_if.sv
// Interface: access events from host decoder to the scan engine
interface dsp_if;
  logic       wr_data;
  logic       wr_cmd;
  logic [7:0] wr_byte;
  logic       win;
  logic       busy;
  modport host (output wr_data, output wr_cmd, output wr_byte, input win, input busy);
  modport scan (input wr_data, input wr_cmd, input wr_byte, output win, output busy);
endinterface

// ### verilog/dsp_pkg.sv
// Package: constants and types of the dual style host bus port
package dsp_pkg;
  // ==========================================================================
  // Bus style and access decode
  localparam logic       STYLE_STROBE    = 1'b0;
  localparam logic       STYLE_ENABLE    = 1'b1;
  localparam int         DATA_W          = 8;
  localparam logic [7:0] STATUS_RST      = 8'h00;
  localparam logic [7:0] RD_DATA_RST     = 8'h00;
  // ==========================================================================
  // Panel scan geometry
  localparam int         ROWS            = 128;
  localparam int         COLS            = 240;
  localparam int         STATUS_BUSY_BIT = 6;
  localparam int         STATUS_WIN_BIT  = 7;
  // ==========================================================================
  // Timing
  localparam int         CLK_MHZ         = 100;
  localparam int         READY_LEAD_NS   = 3500;
  localparam int         READY_LEAD_CYC  = (READY_LEAD_NS * CLK_MHZ) / 1000;
  localparam int         WINDOW_CYC      = 2 * READY_LEAD_CYC;
  localparam int         CNT_W           = 16;
  typedef enum logic [2:0] {
    DSP_IDLE  = 3'b001,
    DSP_READ  = 3'b010,
    DSP_WRITE = 3'b100
  } dsp_acc_t;
  typedef enum logic [1:0] {
    DSP_SCAN = 2'b01,
    DSP_WIN  = 2'b10
  } dsp_scan_t;
endpackage

// ### verilog/dsp_port.sv
// Module: dual style eight bit host port with panel scan
module dsp_port
  import dsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       controller_clear_n,
  input  wire logic       bus_style_select,
  input  wire logic       chip_select_n,
  input  wire logic       read_enable,
  input  wire logic       write_direction,
  input  wire logic       register_select,
  input  wire logic       self_check_pin,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe_n,
  output logic            ready,
  output logic            row_strobe,
  output logic      [7:0] last_data,
  output logic      [7:0] last_cmd
);
  // ==========================================================================
  // Input synchronisers, pulled-up pins arrive as high when left open
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic [7:0] d1_ff;
  logic [7:0] d2_ff;
  wire  [5:0] pin_raw = {controller_clear_n, bus_style_select, chip_select_n,
                         read_enable, write_direction, register_select};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 6'h3f;
      s2_ff <= 6'h3f;
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      d1_ff <= host_data_bus_in;
      d2_ff <= d1_ff;
    end
  end
  wire clr_n_s = s2_ff[5];
  wire style_s = s2_ff[4];
  wire cs_n_s  = s2_ff[3];
  wire rde_s   = s2_ff[2];
  wire wrd_s   = s2_ff[1];
  wire rs_s    = s2_ff[0];
  // ==========================================================================
  // Style latch: caught once after release, since the pin is meant to be static
  logic style_ff;
  logic style_vld_ff;
  logic [1:0] settle_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      style_ff     <= STYLE_STROBE;
      style_vld_ff <= 1'b0;
      settle_ff    <= 2'b00;
    end else if (!style_vld_ff) begin
      settle_ff <= settle_ff + 2'b01;
      if (settle_ff == 2'b11) begin
        style_ff     <= style_s;
        style_vld_ff <= 1'b1;
      end
    end
  end
  // ==========================================================================
  // Access decode, chip select gates both styles
  wire sel      = !cs_n_s && style_vld_ff && clr_n_s;
  wire rd_strb  = !rde_s;
  wire wr_strb  = !wrd_s;
  wire en_rd    = rde_s && wrd_s;
  wire en_wr    = rde_s && !wrd_s;
  wire rd_act   = sel && ((style_ff == STYLE_STROBE) ? (rd_strb && !wr_strb) : en_rd);
  wire wr_act   = sel && ((style_ff == STYLE_STROBE) ? (wr_strb && !rd_strb) : en_wr);
  // ==========================================================================
  // Access machine: one event per strobe, taken at the strobe's leading edge
  dsp_if      acc ();
  dsp_acc_t   st_ff;
  dsp_acc_t   nxt_st;
  logic [7:0] cmd_ff;
  logic [7:0] dat_ff;
  logic [7:0] out_ff;
  logic       oe_n_ff;
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      DSP_IDLE:  nxt_st = rd_act ? DSP_READ : (wr_act ? DSP_WRITE : DSP_IDLE);
      DSP_READ:  nxt_st = rd_act ? DSP_READ : DSP_IDLE;
      DSP_WRITE: nxt_st = wr_act ? DSP_WRITE : DSP_IDLE;
      default:   nxt_st = DSP_IDLE;
    endcase
  end
  wire       wr_fire   = (st_ff == DSP_IDLE) && (nxt_st == DSP_WRITE);
  assign acc.wr_data   = wr_fire && !rs_s;
  assign acc.wr_cmd    = wr_fire && rs_s;
  assign acc.wr_byte   = d2_ff;
  wire [7:0] status_w  = {acc.win, acc.busy, 6'h00};
  wire [7:0] rd_word   = rs_s ? dat_ff : status_w;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff   <= DSP_IDLE;
      cmd_ff  <= 8'h00;
      dat_ff  <= RD_DATA_RST;
      out_ff  <= STATUS_RST;
      oe_n_ff <= 1'b1;
    end else if (!clr_n_s) begin
      st_ff   <= DSP_IDLE;
      cmd_ff  <= 8'h00;
      dat_ff  <= RD_DATA_RST;
      out_ff  <= STATUS_RST;
      oe_n_ff <= 1'b1;
    end else begin
      st_ff   <= nxt_st;
      oe_n_ff <= !(nxt_st == DSP_READ);
      if (nxt_st == DSP_READ) begin
        out_ff <= rd_word;
      end
      if (acc.wr_cmd) begin
        cmd_ff <= acc.wr_byte;
      end
      if (acc.wr_data) begin
        dat_ff <= acc.wr_byte;
      end
    end
  end
  assign host_data_bus_out  = out_ff;
  assign host_data_bus_oe_n = oe_n_ff;
  assign last_data          = dat_ff;
  assign last_cmd           = cmd_ff;
  dsp_scan u_scan (
    .clk           (clk),
    .rst_n         (rst_n),
    .acc           (acc.scan),
    .ready_ff      (ready),
    .row_strobe_ff (row_strobe)
  );
endmodule

// ### verilog/dsp_scan.sv
// Module: row by row panel refresh and ready window
module dsp_scan
  import dsp_pkg::*;
#(
  parameter int ROWS_P = ROWS,
  parameter int COLS_P = COLS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  dsp_if.scan       acc,
  output logic      ready_ff,
  output logic      row_strobe_ff
);
  // ==========================================================================
  // Counters
  dsp_scan_t        st_ff;
  logic [CNT_W-1:0] col_ff;
  logic [CNT_W-1:0] row_ff;
  logic [CNT_W-1:0] win_ff;
  wire              last_col = (col_ff == CNT_W'(COLS_P - 1));
  wire              last_row = (row_ff == CNT_W'(ROWS_P - 1));
  wire              win_end  = (win_ff == CNT_W'(WINDOW_CYC - 1));
  wire              lead_hit = (win_ff == CNT_W'(WINDOW_CYC - READY_LEAD_CYC - 1));
  assign acc.win  = (st_ff == DSP_WIN);
  assign acc.busy = (st_ff == DSP_SCAN);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff         <= DSP_SCAN;
      col_ff        <= '0;
      row_ff        <= '0;
      win_ff        <= '0;
      ready_ff      <= 1'b0;
      row_strobe_ff <= 1'b0;
    end else begin
      row_strobe_ff <= 1'b0;
      unique case (st_ff)
        DSP_SCAN: begin
          col_ff <= last_col ? '0 : col_ff + 1'b1;
          if (last_col) begin
            row_strobe_ff <= 1'b1;
            row_ff        <= last_row ? '0 : row_ff + 1'b1;
            if (last_row) begin
              st_ff    <= DSP_WIN;
              ready_ff <= 1'b1;
              win_ff   <= '0;
            end
          end
        end
        DSP_WIN: begin
          win_ff <= win_ff + 1'b1;
          // Low well before first row, so the host stops in time
          if (lead_hit) begin
            ready_ff <= 1'b0;
          end
          if (win_end) begin
            st_ff <= DSP_SCAN;
          end
        end
      endcase
    end
  end
endmodule
